// ==== hdl/css_defs.vh ====
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH

// Register port offsets
`define CSS_OFS_GATE_CTRL   2'h0
`define CSS_OFS_STATUS      2'h1
`define CSS_OFS_FUSE_VIEW   2'h2

// Gate control register fields
`define CSS_GC_SLEEP_CORE   0
`define CSS_GC_STOP_PERIPH  1
`define CSS_GC_STOP_ASYNC   2
`define CSS_GC_STOP_CONV    3
`define CSS_GC_DEEP_SLEEP   4
`define CSS_GC_WIDTH        5
`define CSS_GC_RESET        5'h00

// Factory fuse values, a one is unprogrammed
`define CSS_SEL_RESET       4'h1
`define CSS_SUT_RESET       2'h2
`define CSS_AMP_RESET       1'h1

// Source kinds decoded from the source select field
`define CSS_SRC_CRYSTAL     3'h0
`define CSS_SRC_LOWFREQ     3'h1
`define CSS_SRC_EXT_RC      3'h2
`define CSS_SRC_INT_RC      3'h3
`define CSS_SRC_EXT_CLK     3'h4

// Select code boundaries
`define CSS_SEL_CRYSTAL_LO  4'hA
`define CSS_SEL_LOWFREQ     4'h9
`define CSS_SEL_EXT_RC_LO   4'h5
`define CSS_SEL_INT_RC_LO   4'h1

// Crystal frequency range codes
`define CSS_RNG_0P4_0P9     2'h0
`define CSS_RNG_0P9_3P0     2'h1
`define CSS_RNG_3P0_8P0     2'h2
`define CSS_RNG_1P0_UP      2'h3

// Start-up counts, in oscillator cycles
`define CSS_CNT_W           17
`define CSS_WAKE_258        17'h0_0102
`define CSS_WAKE_1K         17'h0_0400
`define CSS_WAKE_16K        17'h0_4000
`define CSS_WAKE_OTHER      17'h0_0006
`define CSS_DLY_NONE        17'h0_0000
`define CSS_DLY_4K          17'h0_1000
`define CSS_DLY_64K         17'h1_0000

`endif

// ==== hdl/css_tick_counter.v ====
`timescale 1ns/1ps
// Counts rising edges of a slow oscillator seen on a pin
module css_tick_counter (
  // Clock and reset
  input  wire                   mclk,
  input  wire                   rst_b,
  // Oscillator pin level
  input  wire                   rawIn,
  // Control
  input  wire                   start,
  input  wire [16:0]            target,
  // Status
  output reg                    busy,
  output reg                    done
);

  reg        syncA;     // First stage, read only by syncB
  reg        syncB;     // Second stage
  reg        syncC;     // Third stage
  reg        level;     // Accepted level
  reg        levelPrev; // Level one cycle ago
  reg [16:0] count;     // Edges seen so far
  wire       tick;      // One accepted rising edge

  assign tick = level & ~levelPrev;

  // Three flip-flop synchroniser, level accepted when stages two and three agree
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      syncA     <= 1'b0;
      syncB     <= 1'b0;
      syncC     <= 1'b0;
      level     <= 1'b0;
      levelPrev <= 1'b0;
    end else begin
      syncA     <= rawIn;
      syncB     <= syncA;
      syncC     <= syncB;
      if (syncB == syncC) begin
        level <= syncC;
      end
      levelPrev <= level;
    end
  end

  // Edge counter with a one-cycle done pulse
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= 17'h0_0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= 17'h0_0000;
        // Zero length finishes at once
        if (target == 17'h0_0000) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          busy <= 1'b1;
        end
      end else if (busy && tick) begin
        if (count + 17'h0_0001 == target) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        count <= count + 17'h0_0001;
      end
    end
  end

endmodule // css_tick_counter

// ==== hdl/css_clock_startup.v ====
// Overview of operation
// - Decode source select into five clock sources
// - Fuse one means unprogrammed, zero programmed
// - Wake from deep sleep counts source cycles
// - Reset adds none, 4096 or 65536 watchdog cycles
// - Factory default: internal RC one, start-up two
// - Amplifier option picks full or reduced swing
// - Crystal select bits give frequency range at reduced swing
// - Low bit plus start-up field set crystal wake count
// - Low bit plus start-up field set crystal reset delay
// - Five separately gated clock domains
// - Core clock stop halts core state
// - Program memory clock follows core clock
// - Converter clock runs while core is halted in light sleep
// - Peripheral clock for timers, serial, interrupts
// - Async timer only with internal oscillator
`timescale 1ns/1ps
`include "css_defs.vh"

module css_clock_startup #(
  parameter [16:0] DLY_SHORT = `CSS_DLY_4K,   // Short reset delay, watchdog cycles
  parameter [16:0] DLY_LONG  = `CSS_DLY_64K,  // Long reset delay, watchdog cycles
  parameter [16:0] WAKE_LONG = `CSS_WAKE_16K  // Longest wake count, source cycles
) (
  // Clock and reset
  input  wire                   mclk,
  input  wire                   rst_b,
  // Fuse field levels
  input  wire [3:0]             clockSourceSelect,
  input  wire [1:0]             startupTimeSelect,
  input  wire                   amplifierSwingOption,
  // Oscillator levels from pins
  input  wire                   watchdogOscIn,
  input  wire                   sourceClockIn,
  // Wake event from interrupt logic
  input  wire                   wakeEvent,
  // Register port
  input  wire [1:0]             regAddr,
  input  wire [7:0]             regWrData,
  input  wire                   regWrite,
  input  wire                   regRead,
  output reg  [7:0]             regRdData,
  // Clock domain enables
  output reg                    coreClockEn,
  output reg                    programMemoryClockEn,
  output reg                    peripheralClockEn,
  output reg                    asyncTimerClockEn,
  output reg                    converterClockEn,
  // Reset and oscillator setup
  output reg                    internalReset_b,
  output reg                    fullSwingAmp,
  output reg  [1:0]             crystalRange,
  output reg  [2:0]             sourceKind
);

  // Start-up sequence states
  localparam [2:0] ST_LATCH  = 3'h0;  // Catch fuses after reset release
  localparam [2:0] ST_DELAY  = 3'h1;  // Watchdog-timed reset delay
  localparam [2:0] ST_START  = 3'h2;  // Source-timed oscillator start
  localparam [2:0] ST_RUN    = 3'h3;  // Core running
  localparam [2:0] ST_SLEEP  = 3'h4;  // Core halted

  // Sequence after reset release:
  // One cycle in ST_LATCH to catch the fuse levels.
  // Until then the latches show the factory values.
  // ST_DELAY starts the watchdog-timed counter once.
  // The start strobe is held off while busy or done.
  // A zero delay finishes in the cycle after start.
  // Delay done starts the source-timed counter.
  // Internal reset lifts as ST_START is entered.
  // Source count done moves the sequence to ST_RUN.
  // Core and program memory enables follow one edge later.
  //
  // Sleep handling:
  // Software sets the sleep bit in the gate control word.
  // ST_RUN then moves to ST_SLEEP at the next edge.
  // A wake event in light sleep returns to ST_RUN at once.
  // In deep sleep the oscillator is taken as stopped.
  // Deep wake therefore reruns the source-timed count.
  // Wake clears the sleep and deep sleep bits.
  // A register write in the same cycle wins over that clear.
  //
  // Domain enables:
  // Core and program memory run only in ST_RUN.
  // Peripheral and converter run in ST_RUN and light sleep.
  // Deep sleep stops the peripheral and converter domains.
  // Each of those two has its own stop bit as well.
  // The async timer needs the internal RC source.
  // It keeps running through both sleep kinds.
  //
  // Hazards and limits:
  // Fuses are read once; later pin changes are ignored.
  // Both counters see raw oscillator levels through a
  // three-stage synchroniser, so each oscillator phase
  // must span at least three system clocks.
  // Edges arriving while a counter is idle are dropped.
  // The enables are levels for external clock gates,
  // not gated clocks themselves.
  // Reset delay lengths are parameters so that tests
  // can shorten them; the defaults are the real counts.
  // Non-crystal sources use a short fixed wake count.

  reg  [2:0]             state;          // Current state
  reg  [2:0]             next_state;     // Next state
  reg  [3:0]             selLatch;       // Captured source select
  reg  [1:0]             sutLatch;       // Captured start-up field
  reg                    ampLatch;       // Captured amplifier option
  reg  [`CSS_GC_WIDTH-1:0] gateCtrl;     // Software gate control
  reg                    delayStart;     // Start watchdog count
  reg                    wakeStart;      // Start source count
  reg  [16:0]            delayTarget;    // Reset delay length
  reg  [16:0]            wakeTarget;     // Wake count length
  reg  [2:0]             next_kind;      // Decoded source kind
  reg  [1:0]             next_range;     // Decoded crystal range
  wire [2:0]             tableIdx;       // Low select bit and start-up field
  wire                   delayBusy;      // Watchdog count running
  wire                   delayDone;      // Watchdog count finished
  wire                   wakeBusy;       // Source count running
  wire                   wakeDone;       // Source count finished
  wire                   asyncAllowed;   // Async timer permitted
  wire                   deepSleep;      // Oscillator stopped in sleep
  wire                   coreOn;         // Core may be clocked

  assign tableIdx     = {selLatch[0], sutLatch};
  assign deepSleep    = gateCtrl[`CSS_GC_DEEP_SLEEP];
  assign coreOn       = (state == ST_RUN);
  // Internal RC runs at 1 MHz or more, well above four times 32 kHz
  assign asyncAllowed = (next_kind == `CSS_SRC_INT_RC);

  // Fuses caught once after reset release, factory values until then
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      selLatch <= `CSS_SEL_RESET;
      sutLatch <= `CSS_SUT_RESET;
      ampLatch <= `CSS_AMP_RESET;
    end else if (state == ST_LATCH) begin
      selLatch <= clockSourceSelect;
      sutLatch <= startupTimeSelect;
      ampLatch <= amplifierSwingOption;
    end
  end

  // Source kind from select field ranges
  always @* begin
    if (selLatch >= `CSS_SEL_CRYSTAL_LO) begin
      next_kind = `CSS_SRC_CRYSTAL;
    end else if (selLatch == `CSS_SEL_LOWFREQ) begin
      next_kind = `CSS_SRC_LOWFREQ;
    end else if (selLatch >= `CSS_SEL_EXT_RC_LO) begin
      next_kind = `CSS_SRC_EXT_RC;
    end else if (selLatch >= `CSS_SEL_INT_RC_LO) begin
      next_kind = `CSS_SRC_INT_RC;
    end else begin
      next_kind = `CSS_SRC_EXT_CLK;
    end
  end

  // Crystal range; a programmed (zero) option means wide range
  always @* begin
    if (ampLatch == 1'b0) begin
      next_range = `CSS_RNG_1P0_UP;
    end else begin
      case (selLatch[3:1])
        3'h5:    next_range = `CSS_RNG_0P4_0P9;
        3'h6:    next_range = `CSS_RNG_0P9_3P0;
        default: next_range = `CSS_RNG_3P0_8P0;
      endcase
    end
  end

  // Wake count and reset delay lengths
  always @* begin
    if (next_kind == `CSS_SRC_CRYSTAL) begin
      case (tableIdx)
        3'h0, 3'h1:       wakeTarget = `CSS_WAKE_258;
        3'h2, 3'h3, 3'h4: wakeTarget = `CSS_WAKE_1K;
        default:          wakeTarget = WAKE_LONG;
      endcase
      case (tableIdx)
        3'h2, 3'h5:       delayTarget = `CSS_DLY_NONE;
        3'h0, 3'h3, 3'h6: delayTarget = DLY_SHORT;
        default:          delayTarget = DLY_LONG;
      endcase
    end else begin
      // Other sources use a short fixed wake count
      wakeTarget = `CSS_WAKE_OTHER;
      case (sutLatch)
        2'h0:    delayTarget = `CSS_DLY_NONE;
        2'h1:    delayTarget = DLY_SHORT;
        default: delayTarget = DLY_LONG;
      endcase
    end
  end

  // Watchdog oscillator delay counter
  css_tick_counter u_delayCounter (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .rawIn  (watchdogOscIn),
    .start  (delayStart),
    .target (delayTarget),
    .busy   (delayBusy),
    .done   (delayDone)
  );

  // Selected source start-up counter
  css_tick_counter u_wakeCounter (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .rawIn  (sourceClockIn),
    .start  (wakeStart),
    .target (wakeTarget),
    .busy   (wakeBusy),
    .done   (wakeDone)
  );

  // Sequence control
  always @* begin
    next_state = state;
    delayStart = 1'b0;
    wakeStart  = 1'b0;
    case (state)
      ST_LATCH: begin
        // Fuses settle this cycle, delay starts next
        next_state = ST_DELAY;
      end
      ST_DELAY: begin
        if (!delayBusy && !delayDone) begin
          delayStart = 1'b1;
        end else if (delayDone) begin
          wakeStart  = 1'b1;
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (wakeDone) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (gateCtrl[`CSS_GC_SLEEP_CORE]) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wakeEvent) begin
          if (deepSleep) begin
            wakeStart  = 1'b1;
            next_state = ST_START;
          end else begin
            next_state = ST_RUN;
          end
        end
      end
      default: begin
        next_state = ST_LATCH;
      end
    endcase
  end

  // State register; delayStart fires once since busy rises next cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_LATCH;
    end else begin
      state <= next_state;
    end
  end

  // Gate control register, sleep bits cleared on wake
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gateCtrl <= `CSS_GC_RESET;
    end else if (regWrite && regAddr == `CSS_OFS_GATE_CTRL) begin
      gateCtrl <= regWrData[`CSS_GC_WIDTH-1:0];
    end else if (state == ST_SLEEP && wakeEvent) begin
      gateCtrl[`CSS_GC_SLEEP_CORE] <= 1'b0;
      gateCtrl[`CSS_GC_DEEP_SLEEP] <= 1'b0;
    end
  end

  // Domain enables and decoded setup outputs
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      coreClockEn          <= 1'b0;
      programMemoryClockEn <= 1'b0;
      peripheralClockEn    <= 1'b0;
      asyncTimerClockEn    <= 1'b0;
      converterClockEn     <= 1'b0;
      internalReset_b      <= 1'b0;
      fullSwingAmp         <= 1'b0;
      crystalRange         <= 2'h0;
      sourceKind           <= 3'h0;
    end else begin
      // Core state only clocked while running
      coreClockEn          <= coreOn;
      programMemoryClockEn <= coreOn;
      // Peripheral clock stops in deep sleep or on request
      peripheralClockEn    <= (state >= ST_RUN) && !deepSleep
                              && !gateCtrl[`CSS_GC_STOP_PERIPH];
      // Async timer keeps running through sleep when allowed
      asyncTimerClockEn    <= (state >= ST_RUN) && asyncAllowed
                              && !gateCtrl[`CSS_GC_STOP_ASYNC];
      // Converter runs while core is halted, not in deep sleep
      converterClockEn     <= (state >= ST_RUN) && !deepSleep
                              && !gateCtrl[`CSS_GC_STOP_CONV];
      internalReset_b      <= (next_state != ST_LATCH)
                              && (next_state != ST_DELAY);
      fullSwingAmp         <= ~ampLatch;
      crystalRange         <= next_range;
      sourceKind           <= next_kind;
    end
  end

  // Read data, one cycle after the read strobe
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `CSS_OFS_GATE_CTRL: regRdData <= {3'h0, gateCtrl};
        `CSS_OFS_STATUS:    regRdData <= {wakeBusy, delayBusy, asyncAllowed,
                                          2'h0, state};
        `CSS_OFS_FUSE_VIEW: regRdData <= {1'b0, ampLatch, sutLatch, selLatch};
        default:            regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // css_clock_startup

// ==== tb/css_clock_startup_monitor.sv ====
`timescale 1ns/1ps
// Watches the start-up block at its ports
module css_clock_startup_monitor (
  // Clock and reset
  input wire       mclk,
  input wire       rst_b,
  // Fuse levels
  input wire [3:0] clockSourceSelect,
  input wire       amplifierSwingOption,
  // Clock domain enables
  input wire       coreClockEn,
  input wire       programMemoryClockEn,
  input wire       peripheralClockEn,
  input wire       asyncTimerClockEn,
  input wire       converterClockEn,
  // Reset and oscillator setup
  input wire       internalReset_b,
  input wire       fullSwingAmp,
  input wire [1:0] crystalRange,
  input wire [2:0] sourceKind
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  pm_follows_core_a: assert property (programMemoryClockEn == coreClockEn)
    else $error("program memory enable differs from core enable");
  core_after_reset_a: assert property (coreClockEn |-> internalReset_b)
    else $error("core enabled while internal reset held");
  core_late_a: assert property ($rose(coreClockEn) |-> $past(internalReset_b, 3))
    else $error("core enabled too soon after reset release");
  domains_in_reset_a: assert property (!internalReset_b |-> !peripheralClockEn && !converterClockEn)
    else $error("domain enabled while internal reset held");
  async_int_rc_a: assert property (asyncTimerClockEn |-> sourceKind == 3'h3)
    else $error("async timer clock without internal oscillator");
  swing_follow_a: assert property (internalReset_b |-> fullSwingAmp == ~amplifierSwingOption)
    else $error("amplifier swing does not follow option");
  kind_crystal_a: assert property (internalReset_b && clockSourceSelect >= 4'hA |-> sourceKind == 3'h0)
    else $error("crystal code not decoded as crystal");
  kind_ext_clk_a: assert property (internalReset_b && clockSourceSelect == 4'h0 |-> sourceKind == 3'h4)
    else $error("code zero not decoded as external clock");
  range_full_a: assert property (internalReset_b && clockSourceSelect >= 4'hA && !amplifierSwingOption
      |-> crystalRange == 2'h3)
    else $error("full swing crystal range wrong");
endmodule // css_clock_startup_monitor

bind css_clock_startup css_clock_startup_monitor i_css_clock_startup_monitor (
  .mclk(mclk), .rst_b(rst_b), .clockSourceSelect(clockSourceSelect),
  .amplifierSwingOption(amplifierSwingOption), .coreClockEn(coreClockEn),
  .programMemoryClockEn(programMemoryClockEn), .peripheralClockEn(peripheralClockEn),
  .asyncTimerClockEn(asyncTimerClockEn), .converterClockEn(converterClockEn),
  .internalReset_b(internalReset_b), .fullSwingAmp(fullSwingAmp),
  .crystalRange(crystalRange), .sourceKind(sourceKind));

// ==== tb/css_osc_model.sv ====
`timescale 1ns/1ps
// Free-running oscillator standing in for a crystal, resonator or watchdog source
module css_osc_model #(
  parameter real HALF_NS = 130.0  // Half period, kept above three system clocks
) (
  // Oscillator level
  output logic osc
);
  // Runs free once powered, phase unrelated to the system clock
  initial begin
    osc = 1'b0;
    forever #(HALF_NS) osc = ~osc;
  end
endmodule // css_osc_model

// ==== tb/tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for clock source decode and start-up sequencing
module tb;
  logic        mclk = 0;       // System clock
  logic        rst_b = 0;      // Reset, active low
  logic [3:0]  sel = 4'h1;     // Source select fuses
  logic [1:0]  sut = 2'h2;     // Start-up fuses
  logic        amp = 1;        // Amplifier option fuse
  logic        wake = 0;       // Wake event
  logic [1:0]  regAddr = 0;    // Register port
  logic [7:0]  regWrData = 0;
  logic        regWrite = 0;
  logic        regRead = 0;
  wire  [7:0]  regRdData;
  wire         wdOsc, srcOsc;  // Oscillator levels
  wire         coreEn, pmEn, perEn, asyEn, convEn, intRst_b, fullSwing;
  wire  [1:0]  crystalRange;
  wire  [2:0]  sourceKind;
  integer      errTotal = 0, samplesChecked = 0, cycles = 0;
  integer      wdCnt = 0, srcCnt = 0;

  always #20 mclk = ~mclk;
  always @(posedge wdOsc) wdCnt++;
  always @(posedge srcOsc) srcCnt++;

  css_osc_model #(.HALF_NS(170.0)) i_wd_osc (.osc(wdOsc));
  css_osc_model #(.HALF_NS(130.0)) i_src_osc (.osc(srcOsc));

  css_clock_startup #(.DLY_SHORT(17'h0_0008), .DLY_LONG(17'h0_0010),
    .WAKE_LONG(17'h0_000C)) i_css_clock_startup (
    .mclk(mclk), .rst_b(rst_b), .clockSourceSelect(sel), .startupTimeSelect(sut),
    .amplifierSwingOption(amp), .watchdogOscIn(wdOsc), .sourceClockIn(srcOsc),
    .wakeEvent(wake), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData), .coreClockEn(coreEn),
    .programMemoryClockEn(pmEn), .peripheralClockEn(perEn), .asyncTimerClockEn(asyEn),
    .converterClockEn(convEn), .internalReset_b(intRst_b), .fullSwingAmp(fullSwing),
    .crystalRange(crystalRange), .sourceKind(sourceKind));

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("checked %0d, errors %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      errTotal++;
      give_verdict;
    end
  end

  // Fuses change only while reset is held
  task boot(input logic [3:0] s, input logic [1:0] t, input logic a);
    @(posedge mclk);
    rst_b <= 0; sel <= s; sut <= t; amp <= a;
    repeat (6) @(posedge mclk);
    rst_b <= 1;
  endtask

  task reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a; regWrData <= d; regWrite <= 1;
    @(posedge mclk);
    regWrite <= 0;
  endtask

  task reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge mclk);
    regAddr <= a; regRead <= 1;
    @(posedge mclk);
    regRead <= 0;
    @(negedge mclk);
    d = regRdData;
  endtask

  task pulse_wake;
    @(posedge mclk) wake <= 1;
    @(posedge mclk) wake <= 0;
  endtask

  // Every select code under both amplifier settings
  task decode_all;
    integer s, a;
    logic [2:0] k;
    for (a = 0; a < 2; a++) for (s = 0; s < 16; s++) begin
      boot(s[3:0], 2'b00, a[0]);
      repeat (3) @(negedge mclk);
      k = s >= 10 ? 3'h0 : s == 9 ? 3'h1 : s >= 5 ? 3'h2 : s >= 1 ? 3'h3 : 3'h4;
      check(sourceKind, k);
      check(fullSwing, !a);
      if (s >= 10) check(crystalRange, a ? s[3:1] - 5 : 3);
    end
  endtask

  // Crystal delay and wake counts for all eight low-bit and start-up codes
  task crystal_startup;
    integer k, n, wk, dl;
    for (k = 0; k < 8; k++) begin
      // 258-cycle codes run here against a resonator-like source only
      wk = k < 2 ? 258 : k < 5 ? 1024 : 12;
      dl = (k == 2 || k == 5) ? 0 : (k == 0 || k == 3 || k == 6) ? 8 : 16;
      boot({3'b111, k[2]}, k[1:0], 1'b1);
      n = wdCnt;
      wait (intRst_b === 1'b1);
      n = wdCnt - n;
      check(n + 3 >= dl && n <= dl + 3, 1);
      n = srcCnt;
      wait (coreEn === 1'b1);
      n = srcCnt - n;
      check(n + 3 >= wk && n <= wk + 3, 1);
      @(negedge mclk);
      check(asyEn, 0);
    end
  endtask

  // Factory setting, register port, light and deep sleep
  task sleep_wake;
    logic [7:0] d;
    integer n;
    boot(4'h1, 2'b10, 1'b1);
    wait (coreEn === 1'b1);
    @(negedge mclk);
    check(asyEn, 1);
    reg_rd(2'h2, d);
    check(d, 8'h61);
    reg_rd(2'h1, d);
    check(d, 8'h23);
    reg_wr(2'h3, 8'hFF);
    reg_rd(2'h3, d);
    check(d, 0);
    reg_rd(2'h0, d);
    check(d, 0);
    reg_wr(2'h0, 8'h01);
    repeat (3) @(negedge mclk);
    check({coreEn, pmEn, convEn, perEn}, 4'b0011);
    pulse_wake;
    repeat (3) @(negedge mclk);
    check({coreEn, pmEn}, 2'b11);
    reg_rd(2'h0, d);
    check(d, 0);
    reg_wr(2'h0, 8'h0E);
    repeat (2) @(negedge mclk);
    check({perEn, asyEn, convEn, coreEn}, 4'b0001);
    reg_wr(2'h0, 8'h11);
    wait (coreEn === 1'b0);
    @(negedge mclk);
    check({perEn, convEn}, 0);
    n = srcCnt;
    pulse_wake;
    wait (coreEn === 1'b1);
    n = srcCnt - n;
    check(n >= 5 && n <= 10, 1);
  endtask

  initial begin
    decode_all;
    crystal_startup;
    sleep_wake;
    give_verdict;
  end
endmodule // tb
